// ==== interrupt_vector_priority.sv ====
`timescale 1ns/1ps
`include "irq_vec_consts.svh"

module interrupt_vector_priority
   import irq_vec_pkg::*;
(
   input wire logic ref_clk, // system clock
   input wire logic reset, // async, active high
   input wire logic clk_en, // freezes state when low
   input wire logic [20:0] vector_base, // table base, word address
   input wire logic [45:0] irq_req, // request level per vector
   input wire logic [9:0] debug_level, // 2 bits per vector 6..10
   input wire logic [57:0] periph_level, // 2 bits per vector 16..44
   input wire logic fetch_ack, // core takes the vector
   output logic irq_valid, // a vector is being presented
   output irq_vec_pkg::vec_t irq_vector, // granted vector number
   output irq_vec_pkg::addr_t fetch_addr, // entry fetch address
   output logic [1:0] irq_level_out, // granted level 0..3
   output logic irq_low_prio, // granted request is level -1
   output logic [18:0] jump_mask // reachable jump target bits
);

   // ****************************************
   // encoded levels
   // ****************************************
   // each level is held one above its number so that level -1 still
   // fits an unsigned compare
   localparam int NUM_LVL = 5;
   localparam level_t ENC_LP = 3'd0;
   localparam level_t ENC_L0 = 3'd1;
   localparam level_t ENC_L1 = 3'd2;
   localparam level_t ENC_L2 = 3'd3;
   localparam level_t ENC_L3 = 3'd4;

   // ****************************************
   // table holes
   // ****************************************
   // holes never raise, so they never need a level of their own
   localparam logic [`NUM_VEC-1:0] HOLES = `HOLE_MASK;

   // ****************************************
   // programmed levels
   // ****************************************
   // two bits per entry, lowest entry in the lowest bits
   logic [1:0] dbg_prog [`DEBUG_LO:`DEBUG_HI];
   logic [1:0] per_prog [`PERIPH_LO:`PERIPH_HI];
   level_t dbg_enc [`DEBUG_LO:`DEBUG_HI];
   level_t per_enc [`PERIPH_LO:`PERIPH_HI];

   genvar g;
   generate
      for (g = `DEBUG_LO; g <= `DEBUG_HI; g = g + 1) begin : g_dprog
         assign dbg_prog[g] = debug_level[2*(g-`DEBUG_LO) +: 2];
         // programmed 0 would be below the legal range: clamp to 1
         assign dbg_enc[g] = (dbg_prog[g] == 2'd0) ?
            ENC_L1 : level_t'({1'b0, dbg_prog[g]} + 3'd1);
      end
      for (g = `PERIPH_LO; g <= `PERIPH_HI; g = g + 1) begin : g_pprog
         assign per_prog[g] = periph_level[2*(g-`PERIPH_LO) +: 2];
         // level 3 is not allowed here: clamp to 2
         assign per_enc[g] = (per_prog[g] == 2'd3) ?
            ENC_L2 : level_t'({1'b0, per_prog[g]} + 3'd1);
      end
   endgenerate

   // ****************************************
   // per vector level
   // ****************************************
   level_t lvl [0:`NUM_VEC-1];
   logic [`NUM_VEC-1:0] eligible;

   generate
      for (g = 0; g < `NUM_VEC; g = g + 1) begin : g_lvl
         if (g < `FIRST_IRQ_VEC) begin : g_rst
            // reset entries are overlays, not interrupts
            assign lvl[g] = ENC_LP;
            assign eligible[g] = 1'b0;
         end else if (g <= `FIXED3_HI) begin : g_fix3
            assign lvl[g] = ENC_L3;
            assign eligible[g] = irq_req[g];
         end else if (g <= `DEBUG_HI) begin : g_dbg
            assign lvl[g] = dbg_enc[g];
            assign eligible[g] = irq_req[g];
         end else if (g == `SWI2_VEC) begin : g_s2
            assign lvl[g] = ENC_L2;
            assign eligible[g] = irq_req[g];
         end else if (g == `SWI1_VEC) begin : g_s1
            assign lvl[g] = ENC_L1;
            assign eligible[g] = irq_req[g];
         end else if (g == `SWI0_VEC) begin : g_s0
            assign lvl[g] = ENC_L0;
            assign eligible[g] = irq_req[g];
         end else if (HOLES[g]) begin : g_rsv
            // unassigned entries never raise
            assign lvl[g] = ENC_LP;
            assign eligible[g] = 1'b0;
         end else if (g <= `PERIPH_HI) begin : g_per
            // flash 18..20, spi 26..27, converter 40..42 are plain lines
            assign lvl[g] = per_enc[g];
            assign eligible[g] = irq_req[g];
         end else begin : g_lp
            assign lvl[g] = ENC_LP;
            assign eligible[g] = irq_req[g];
         end
      end
   endgenerate

   // ****************************************
   // per level request masks
   // ****************************************
   // one mask per level: picking the level first keeps the tie break
   // a plain find-first instead of a long compare chain
   logic [`NUM_VEC-1:0] lvl_mask [0:NUM_LVL-1];
   genvar v;
   generate
      for (v = 0; v < `NUM_VEC; v = v + 1) begin : g_mask
         assign lvl_mask[0][v] = eligible[v] && (lvl[v] == ENC_LP);
         assign lvl_mask[1][v] = eligible[v] && (lvl[v] == ENC_L0);
         assign lvl_mask[2][v] = eligible[v] && (lvl[v] == ENC_L1);
         assign lvl_mask[3][v] = eligible[v] && (lvl[v] == ENC_L2);
         assign lvl_mask[4][v] = eligible[v] && (lvl[v] == ENC_L3);
      end
   endgenerate

   // ****************************************
   // pending levels
   // ****************************************
   logic [NUM_LVL-1:0] lvl_any;
   assign lvl_any[0] = |lvl_mask[0];
   assign lvl_any[1] = |lvl_mask[1];
   assign lvl_any[2] = |lvl_mask[2];
   assign lvl_any[3] = |lvl_mask[3];
   assign lvl_any[4] = |lvl_mask[4];

   // ****************************************
   // level choice
   // ****************************************
   // one-hot of the highest level that has anything pending
   wire top4 = lvl_any[4];
   wire top3 = lvl_any[3] && !lvl_any[4];
   wire top2 = lvl_any[2] && !(|lvl_any[4:3]);
   wire top1 = lvl_any[1] && !(|lvl_any[4:2]);
   wire top0 = lvl_any[0] && !(|lvl_any[4:1]);
   // anything pending at all
   wire found = |lvl_any;
   wire level_t best_lvl = top4 ? ENC_L3 :
      top3 ? ENC_L2 :
      top2 ? ENC_L1 :
      top1 ? ENC_L0 : ENC_LP;

   // requests that survive the level choice
   wire [`NUM_VEC-1:0] win_mask =
      ({`NUM_VEC{top4}} & lvl_mask[4]) |
      ({`NUM_VEC{top3}} & lvl_mask[3]) |
      ({`NUM_VEC{top2}} & lvl_mask[2]) |
      ({`NUM_VEC{top1}} & lvl_mask[1]) |
      ({`NUM_VEC{top0}} & lvl_mask[0]);

   // ****************************************
   // lowest vector within the level
   // ****************************************
   // carry chain from vector 0 upward: a request wins only if nothing
   // below it survived, so the lowest number goes first
   logic [`NUM_VEC:0] lower_hit;
   logic [`NUM_VEC-1:0] grant_oh;
   assign lower_hit[0] = 1'b0;
   generate
      for (v = 0; v < `NUM_VEC; v = v + 1) begin : g_first
         assign lower_hit[v+1] = lower_hit[v] | win_mask[v];
         assign grant_oh[v] = win_mask[v] && !lower_hit[v];
      end
   endgenerate

   // ****************************************
   // vector number
   // ****************************************
   // each number bit ors the winners that have it set; only one
   // winner exists, so no priority logic is needed here
   logic [`NUM_VEC-1:0] bit_sel [0:`VEC_W-1];
   vec_t best_vec;
   genvar b;
   generate
      for (b = 0; b < `VEC_W; b = b + 1) begin : g_enc
         for (v = 0; v < `NUM_VEC; v = v + 1) begin : g_term
            assign bit_sel[b][v] = grant_oh[v] && (((v >> b) % 2) == 1);
         end
         assign best_vec[b] = |bit_sel[b];
      end
   endgenerate

   // ****************************************
   // entry address
   // ****************************************
   // two words per entry, so the number moves up by one bit
   wire addr_t entry_offset = {14'd0, best_vec, 1'b0};
   wire addr_t entry_addr = addr_t'(vector_base + entry_offset);

   // ****************************************
   // presentation to the core
   // ****************************************
   // a request is offered until the core takes it; there is no timeout
   arb_state_e state_reg, state_next;
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         ARB_IDLE: begin
            if (found) begin
               state_next = ARB_PRESENT;
            end
         end
         ARB_PRESENT: begin
            if (fetch_ack) begin
               state_next = ARB_IDLE;
            end
         end
         default: begin
            state_next = ARB_IDLE;
         end
      endcase
   end

   // vector is re-arbitrated every cycle that a request is pending until the core acknowledges,
   // so a newer, more urgent request still overtakes a waiting one
   wire load = (state_reg == ARB_IDLE) || fetch_ack || found;

   // ****************************************
   // next output values
   // ****************************************
   // level -1 shows as level 0 on the port; the flag tells them apart
   wire level_t lvl_minus1 = level_t'(best_lvl - 3'd1);
   wire [1:0] level_next = (best_lvl == ENC_LP) ? 2'd0 : lvl_minus1[1:0];
   wire low_prio_next = top0;

   // ****************************************
   // state register
   // ****************************************
   // a low clock enable holds every register, arbitration state too
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         state_reg <= ARB_IDLE;
      end else if (clk_en) begin
         state_reg <= state_next;
      end
   end

   // ****************************************
   // output registers
   // ****************************************
   // vector and address load together so they always agree
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         irq_vector <= '0;
      end else if (clk_en && load) begin
         irq_vector <= best_vec;
      end
   end

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         fetch_addr <= `VBA_RESET;
      end else if (clk_en && load) begin
         fetch_addr <= entry_addr;
      end
   end

   // level and low priority flag follow the same load
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         irq_level_out <= 2'd0;
      end else if (clk_en && load) begin
         irq_level_out <= level_next;
      end
   end

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         irq_low_prio <= 1'b0;
      end else if (clk_en && load) begin
         irq_low_prio <= low_prio_next;
      end
   end

   // ****************************************
   // core side outputs
   // ****************************************
   assign irq_valid = (state_reg == ARB_PRESENT);
   // the table cannot reach past this many address bits
   assign jump_mask = {`JUMP_W{1'b1}};

endmodule // interrupt_vector_priority

// ==== irq_vec_consts.svh ====
`ifndef IRQ_VEC_CONSTS_SVH
`define IRQ_VEC_CONSTS_SVH

// ****************************************
// table layout
// ****************************************
`define NUM_VEC 46
`define VEC_W 6
`define ADDR_W 21
`define JUMP_W 19
`define ENTRY_WORDS 2
`define VBA_RESET 21'h00_0000
`define FIRST_IRQ_VEC 2
`define RESET_VEC 0
`define COP_VEC 1
`define FIXED3_LO 2
`define FIXED3_HI 5
`define DEBUG_LO 6
`define DEBUG_HI 10
`define SWI2_VEC 11
`define SWI1_VEC 12
`define SWI0_VEC 13
`define PERIPH_LO 16
`define PERIPH_HI 44
`define LOW_PRIORITY_SOFT_INTERRUPT_VEC 45
`define FLASH_ERR_VEC 18
`define FLASH_CC_VEC 19
`define FLASH_BE_VEC 20
`define SPI_RX_VEC 26
`define SPI_TX_VEC 27
`define CONV_A_VEC 40
`define CONV_B_VEC 41
`define CONV_ZC_VEC 42
`define HOLE_MASK 46'h0006_0020_C000

`endif

// ==== irq_vec_pkg.sv ====
package irq_vec_pkg;
   // encoded level: 0 = level -1, 1..4 = levels 0..3
   typedef logic [2:0] level_t;
   typedef logic [5:0] vec_t;
   typedef logic [20:0] addr_t;
   typedef enum logic [1:0] {
      ARB_IDLE,
      ARB_PRESENT
   } arb_state_e;
endpackage

// ==== vec_checker.sv ====
`timescale 1ns/1ps
module vec_checker (
   input logic ref_clk,
   input logic reset,
   input logic clk_en,
   input logic [20:0] vector_base,
   input logic [45:0] irq_req,
   input logic irq_valid,
   input logic [5:0] irq_vector,
   input logic [20:0] fetch_addr,
   input logic [1:0] irq_level_out,
   input logic irq_low_prio
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (reset);
   addr_a: assert property (irq_valid |->
      fetch_addr == 21'(vector_base + 2 * irq_vector)) else $error("addr");
   skip_a: assert property (irq_valid |-> irq_vector > 1 &&
      !(irq_vector inside {14, 15, 21, 33, 34})) else $error("skip");
   hi_a: assert property (irq_valid && irq_vector < 6 |->
      irq_level_out == 2'h3) else $error("hi");
   swi_a: assert property (irq_valid && irq_vector inside {[11:13]}
      |-> irq_level_out == 2'(13 - irq_vector)) else $error("swi");
   dbg_a: assert property (irq_valid && irq_vector inside {[6:10]}
      |-> irq_level_out != 2'h0) else $error("dbg");
   lp_a: assert property (irq_valid |->
      irq_low_prio == (irq_vector == 6'h2d)) else $error("lp");
   top_a: assert property (irq_valid && $past(clk_en && |irq_req[5:2])
      |-> irq_level_out == 2'h3) else $error("top");
   first_a: assert property (irq_valid && $past(clk_en && irq_req[2])
      |-> irq_vector == 6'h02) else $error("first");
   cover property (irq_valid && irq_low_prio);
   cover property (irq_valid && irq_level_out == 2'h0);
   cover property ($rose(irq_valid));
endmodule // vec_checker
bind interrupt_vector_priority vec_checker u_vec_checker (.*);

// ==== core_model.sv ====
`timescale 1ns/1ps
module core_model (
   input wire logic ref_clk, // system clock
   input wire logic reset, // async, active high
   input wire logic irq_valid, // vector on offer
   output logic fetch_ack // vector taken
);
   // random wait stands for an instruction still finishing
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) fetch_ack <= 1'b0;
      else fetch_ack <= irq_valid && !fetch_ack && $urandom_range(2) == 0;
   end
endmodule // core_model

// ==== interrupt_vector_priority_test.sv ====
`timescale 1ns/1ps
module interrupt_vector_priority_test;
   import irq_vec_pkg::*;
   logic ref_clk = 0, reset = 1, clk_en = 1, fetch_ack, irq_valid, irq_low_prio;
   logic [20:0] vector_base = 21'h0;
   logic [45:0] irq_req = 46'h0;
   logic [9:0] debug_level = 10'h0;
   logic [57:0] periph_level = 58'h0;
   vec_t irq_vector;
   addr_t fetch_addr;
   logic [1:0] irq_level_out;
   logic [18:0] jump_mask;
   int num_errors = 0, checked = 0, e;
   int exp_q[$];
   always #10 ref_clk = ~ref_clk;
   interrupt_vector_priority u_interrupt_vector_priority (.*);
   core_model u_core_model (.*);
   function automatic int lvl(int v);
      int f;
      if (v < 6) return 3;
      f = v < 11 ? debug_level[2*(v-6)+:2] : periph_level[2*(v-16)+:2];
      if (v < 11) return f == 0 ? 1 : f;
      if (v < 14) return 13 - v;
      return v < 45 ? (f == 3 ? 2 : f) : -1;
   endfunction
   // scanning downward with >= lets the lowest vector win a tie
   function automatic int best(logic [45:0] r);
      int b = -1;
      for (int v = 45; v > 1; v--)
         if (r[v] && !(v inside {14, 15, 21, 33, 34}) &&
            (b < 0 || lvl(v) >= lvl(b))) b = v;
      return b;
   endfunction
   task automatic chk(logic [31:0] s, logic [31:0] x);
      checked++;
      if (s !== x) begin
         num_errors++;
         $display("CHECK FAILED %0t seen %0h want %0h", $time, s, x);
      end
   endtask
   always @(posedge ref_clk) if (irq_valid === 1'b1 && fetch_ack === 1'b1) begin
      e = exp_q.size() > 0 ? exp_q.pop_front() : -1;
      chk(irq_vector, e);
      chk(fetch_addr, 21'(vector_base + 2 * e));
      chk(irq_level_out, e == 45 ? 0 : lvl(e));
      chk(irq_low_prio, e == 45);
   end
   task automatic serve(logic [45:0] r);
      int b, n;
      irq_req = r;
      repeat (46) begin
         b = best(irq_req);
         if (b < 0) break;
         exp_q.push_back(b);
         n = 0;
         do begin @(posedge ref_clk); n++; end
         while (!(irq_valid === 1'b1 && fetch_ack === 1'b1) && n < 40);
         @(negedge ref_clk) irq_req[b] = 1'b0;
      end
      repeat (3) @(negedge ref_clk);
      chk(irq_valid, 0);
      chk(exp_q.size(), 0);
   endtask
   task wrap_up;
      $display("checks %0d errors %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      #1_000_000;
      num_errors++;
      wrap_up;
   end
   initial begin
      void'($urandom(27925));
      vector_base = 21'($urandom);
      repeat (2) @(negedge ref_clk);
      reset = 0;
      chk(jump_mask, 19'h7_ffff);
      for (int v = 0; v < 46; v++) begin
         debug_level = 10'($urandom);
         periph_level = 58'({$urandom, $urandom});
         serve(46'h1 << v);
      end
      // frozen by a low clock enable, then served from the reset base
      vector_base = 21'h0;
      clk_en = 0;
      irq_req = 46'h1 << 3;
      repeat (4) @(negedge ref_clk);
      chk(irq_valid, 0);
      clk_en = 1;
      serve(46'h1 << 3);
      repeat (30) serve(46'({$urandom, $urandom} & {$urandom, $urandom}));
      wrap_up;
   end
endmodule // interrupt_vector_priority_test
